// ==== design/fdd_pkg.sv ====
// Package: constants and types for the drive density configuration block
package fdd_pkg;

  // ----------------------------------------
  // Register indices in configuration space
  // ----------------------------------------
  localparam logic [7:0] FDD_IDX_FIRST_FLOPPY = 8'hF4;
  localparam logic [7:0] FDD_IDX_SECOND_FLOPPY = 8'hF5;
  localparam logic [7:0] FDD_CFG_RESET = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FDD_POS_PRECOMP_SKIP = 6;
  localparam int FDD_POS_RATE_TABLE_SEL_HI = 4;
  localparam int FDD_POS_RATE_TABLE_SEL_LO = 3;
  localparam int FDD_POS_DRIVE_TYPE_BIT_A = 1;
  localparam int FDD_POS_DRIVE_TYPE_BIT_B = 0;
  localparam int FDD_POS_FIFO_BIT7 = 7;

  // ----------------------------------------
  // Pin synchroniser depth
  // ----------------------------------------
  localparam int FDD_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    FDD_TABLE_REGULAR = 2'h0,
    FDD_TABLE_THREE_MODE = 2'h1,
    FDD_TABLE_TAPE = 2'h2,
    FDD_TABLE_RESERVED = 2'h3
  } fdd_table_t;

  typedef enum logic [1:0] {
    FDD_SEL_500 = 2'h0,
    FDD_SEL_300 = 2'h1,
    FDD_SEL_250 = 2'h2,
    FDD_SEL_1M = 2'h3
  } fdd_rate_sel_t;

  // Resulting bit rate (MFM figure; FM is half)
  typedef enum logic [2:0] {
    FDD_RATE_250K = 3'h0,
    FDD_RATE_300K = 3'h1,
    FDD_RATE_500K = 3'h3,
    FDD_RATE_1M = 3'h2,
    FDD_RATE_2M = 3'h6
  } fdd_bitrate_t;

  typedef enum logic [1:0] {
    FDD_MODE_AT = 2'h0,
    FDD_MODE_PS2 = 2'h1,
    FDD_MODE_MODEL30 = 2'h3
  } fdd_bus_mode_t;

  typedef struct packed {
    logic precompSkip;
    fdd_table_t rateTable;
    logic driveTypeBitA;
    logic driveTypeBitB;
  } fdd_drive_cfg_t;

  typedef struct packed {
    logic densitySelect;
    logic rateCodeHi;
    logic rateCodeLo;
    fdd_bitrate_t bitRate;
    logic drivePinA;
    logic drivePinB;
  } fdd_density_t;

endpackage

// ==== design/fdd_rate_decode.sv ====
// Rate table decode and density pin routing for one drive
`timescale 1ns/1ps
`default_nettype none

module fdd_rate_decode (
  input wire fdd_pkg::fdd_drive_cfg_t cfg,
  input wire fdd_pkg::fdd_rate_sel_t rateSel,
  output fdd_pkg::fdd_density_t density
);

  logic densitySelect;
  logic rateCodeHi;
  logic rateCodeLo;

  always_comb begin
    densitySelect = (rateSel == fdd_pkg::FDD_SEL_1M) ||
      (rateSel == fdd_pkg::FDD_SEL_500);
    rateCodeHi = rateSel[1];
    rateCodeLo = rateSel[0];
    density.densitySelect = densitySelect;
    density.rateCodeHi = rateCodeHi;
    density.rateCodeLo = rateCodeLo;
    case (rateSel)
      fdd_pkg::FDD_SEL_1M: density.bitRate = fdd_pkg::FDD_RATE_1M;
      fdd_pkg::FDD_SEL_500: density.bitRate = fdd_pkg::FDD_RATE_500K;
      fdd_pkg::FDD_SEL_250: density.bitRate = fdd_pkg::FDD_RATE_250K;
      fdd_pkg::FDD_SEL_300: begin
        case (cfg.rateTable)
          fdd_pkg::FDD_TABLE_THREE_MODE: density.bitRate = fdd_pkg::FDD_RATE_500K;
          fdd_pkg::FDD_TABLE_TAPE: density.bitRate = fdd_pkg::FDD_RATE_2M;
          default: density.bitRate = fdd_pkg::FDD_RATE_300K;
        endcase
      end
      default: density.bitRate = fdd_pkg::FDD_RATE_250K;
    endcase
    case ({cfg.driveTypeBitA, cfg.driveTypeBitB})
      2'h0: begin
        density.drivePinA = densitySelect;
        density.drivePinB = rateCodeLo;
      end
      2'h1: begin
        density.drivePinA = rateCodeHi;
        density.drivePinB = rateCodeLo;
      end
      2'h2: begin
        density.drivePinA = ~densitySelect;
        density.drivePinB = rateCodeLo;
      end
      default: begin
        density.drivePinA = rateCodeLo;
        density.drivePinB = rateCodeHi;
      end
    endcase
  end

endmodule // fdd_rate_decode

`default_nettype wire

// ==== design/fdd_density_config.sv ====
// Per-drive density configuration, DMA/IRQ gating and shared port read drive
`timescale 1ns/1ps
`default_nettype none

// Function
// - Drive registers 0xF4/0xF5 hold precomp skip b6, rate table b4:3, type a/b b1/b0, rest 0.
// - Precomp skip 0 writes with precompensation, 1 writes without.
// - Table 00: select 11/00/01/10 gives 1M/500/300/250k, density 1/1/0/0, rate = select.
// - Drive type bits route density, its inverse and rate bits onto the two pins.
// - The DMA transfer mode comes up as non-burst.
// - IRQ and DACK float and DREQ is ignored while the DMA gate is 0 or power is down.
// - 0x3f7 reads drive bit 7 in AT mode, the whole byte otherwise; IDE reads are not decoded.
module fdd_density_config (
  input wire logic clock,
  input wire logic reset,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgIndex,
  input wire logic [7:0] cfgWriteData,
  output logic [7:0] cfgReadData,
  output logic cfgReadValid,
  input wire logic driveSel,
  input wire logic [1:0] dataRateSel,
  output logic precompEnable,
  output fdd_pkg::fdd_bitrate_t bitRate,
  output logic drivePinA,
  output logic drivePinB,
  input wire logic dmaModeWrite,
  input wire logic dmaModeBurst,
  output logic dmaNonBurst,
  input wire logic dmaGateEnable,
  input wire logic powerDown,
  input wire logic controllerIrq,
  input wire logic controllerDack,
  input wire logic dreqPin,
  output logic irqOut,
  output logic irqOe_n,
  output logic dackOut,
  output logic dackOe_n,
  output logic dreqAccepted,
  input wire fdd_pkg::fdd_bus_mode_t busMode,
  input wire logic hostRead3f7,
  input wire logic [7:0] fdcByte3f7,
  output logic [7:0] busDataOut,
  output logic [7:0] busDataOe_n
);

  // ----------------------------------------
  // Drive configuration registers
  // ----------------------------------------
  fdd_pkg::fdd_drive_cfg_t driveCfg [2];
  fdd_pkg::fdd_drive_cfg_t next_driveCfg [2];
  logic [7:0] readData;
  logic [7:0] next_readData;
  logic readValid;
  logic next_readValid;

  function automatic fdd_pkg::fdd_drive_cfg_t unpackCfg(input logic [7:0] d);
    fdd_pkg::fdd_drive_cfg_t c;
    c.precompSkip = d[fdd_pkg::FDD_POS_PRECOMP_SKIP];
    c.rateTable = fdd_pkg::fdd_table_t'({d[fdd_pkg::FDD_POS_RATE_TABLE_SEL_HI],
                                         d[fdd_pkg::FDD_POS_RATE_TABLE_SEL_LO]});
    c.driveTypeBitA = d[fdd_pkg::FDD_POS_DRIVE_TYPE_BIT_A];
    c.driveTypeBitB = d[fdd_pkg::FDD_POS_DRIVE_TYPE_BIT_B];
    return c;
  endfunction

  function automatic logic [7:0] packCfg(input fdd_pkg::fdd_drive_cfg_t c);
    logic [7:0] d;
    d = 8'h00;
    d[fdd_pkg::FDD_POS_PRECOMP_SKIP] = c.precompSkip;
    d[fdd_pkg::FDD_POS_RATE_TABLE_SEL_HI] = c.rateTable[1];
    d[fdd_pkg::FDD_POS_RATE_TABLE_SEL_LO] = c.rateTable[0];
    d[fdd_pkg::FDD_POS_DRIVE_TYPE_BIT_A] = c.driveTypeBitA;
    d[fdd_pkg::FDD_POS_DRIVE_TYPE_BIT_B] = c.driveTypeBitB;
    return d;
  endfunction

  always_comb begin
    next_driveCfg[0] = driveCfg[0];
    next_driveCfg[1] = driveCfg[1];
    next_readData = readData;
    next_readValid = cfgRead;
    if (cfgWrite && cfgIndex == fdd_pkg::FDD_IDX_FIRST_FLOPPY) begin
      next_driveCfg[0] = unpackCfg(cfgWriteData);
    end
    if (cfgWrite && cfgIndex == fdd_pkg::FDD_IDX_SECOND_FLOPPY) begin
      next_driveCfg[1] = unpackCfg(cfgWriteData);
    end
    if (cfgRead) begin
      case (cfgIndex)
        fdd_pkg::FDD_IDX_FIRST_FLOPPY: next_readData = packCfg(driveCfg[0]);
        fdd_pkg::FDD_IDX_SECOND_FLOPPY: next_readData = packCfg(driveCfg[1]);
        default: next_readData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      driveCfg[0] <= fdd_pkg::fdd_drive_cfg_t'(fdd_pkg::FDD_CFG_RESET[4:0]);
      driveCfg[1] <= fdd_pkg::fdd_drive_cfg_t'(fdd_pkg::FDD_CFG_RESET[4:0]);
      readData <= 8'h00;
      readValid <= 1'b0;
    end else begin
      driveCfg[0] <= next_driveCfg[0];
      driveCfg[1] <= next_driveCfg[1];
      readData <= next_readData;
      readValid <= next_readValid;
    end
  end

  assign cfgReadData = readData;
  assign cfgReadValid = readValid;

  // ----------------------------------------
  // Density decode for the selected drive
  // ----------------------------------------
  fdd_pkg::fdd_density_t density;
  logic nextPrecomp;
  logic precompQ;
  fdd_pkg::fdd_bitrate_t bitRateQ;
  logic pinAQ;
  logic pinBQ;

  fdd_rate_decode decodeUnit (
    .cfg(driveCfg[driveSel]),
    .rateSel(fdd_pkg::fdd_rate_sel_t'(dataRateSel)),
    .density(density)
  );

  always_comb begin
    nextPrecomp = ~driveCfg[driveSel].precompSkip;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      precompQ <= 1'b1;
      bitRateQ <= fdd_pkg::FDD_RATE_500K;
      pinAQ <= 1'b1;
      pinBQ <= 1'b0;
    end else begin
      precompQ <= nextPrecomp;
      bitRateQ <= density.bitRate;
      pinAQ <= density.drivePinA;
      pinBQ <= density.drivePinB;
    end
  end

  assign precompEnable = precompQ;
  assign bitRate = bitRateQ;
  assign drivePinA = pinAQ;
  assign drivePinB = pinBQ;

  // ----------------------------------------
  // DMA mode and IRQ/DACK/DREQ gating
  // ----------------------------------------
  logic nonBurst;
  logic next_nonBurst;
  logic [fdd_pkg::FDD_SYNC_STAGES-1:0] dreqSync;
  logic [fdd_pkg::FDD_SYNC_STAGES-1:0] next_dreqSync;
  logic dreqLevel;
  logic next_dreqLevel;
  logic gateOpen;

  always_comb begin
    next_nonBurst = dmaModeWrite ? ~dmaModeBurst : nonBurst;
    next_dreqSync = {dreqSync[fdd_pkg::FDD_SYNC_STAGES-2:0], dreqPin};
    next_dreqLevel = (dreqSync[1] == dreqSync[2]) ? dreqSync[2] : dreqLevel;
    gateOpen = dmaGateEnable && !powerDown;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      nonBurst <= 1'b1;
      dreqSync <= '0;
      dreqLevel <= 1'b0;
    end else begin
      nonBurst <= next_nonBurst;
      dreqSync <= next_dreqSync;
      dreqLevel <= next_dreqLevel;
    end
  end

  assign dmaNonBurst = nonBurst;
  assign irqOut = controllerIrq;
  assign irqOe_n = ~gateOpen;
  assign dackOut = controllerDack;
  assign dackOe_n = ~gateOpen;
  assign dreqAccepted = dreqLevel && gateOpen;

  // ----------------------------------------
  // Shared 0x3f7 read drive
  // ----------------------------------------
  logic [7:0] next_busData;
  logic [7:0] next_busOe_n;
  logic [7:0] busDataQ;
  logic [7:0] busOeQ_n;

  always_comb begin
    next_busData = 8'h00;
    next_busOe_n = 8'hFF;
    if (hostRead3f7) begin
      next_busData = fdcByte3f7;
      case (busMode)
        fdd_pkg::FDD_MODE_AT: begin
          next_busOe_n[fdd_pkg::FDD_POS_FIFO_BIT7] = 1'b0;
        end
        fdd_pkg::FDD_MODE_PS2, fdd_pkg::FDD_MODE_MODEL30: next_busOe_n = 8'h00;
        default: next_busOe_n = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busDataQ <= 8'h00;
      busOeQ_n <= 8'hFF;
    end else begin
      busDataQ <= next_busData;
      busOeQ_n <= next_busOe_n;
    end
  end

  assign busDataOut = busDataQ;
  assign busDataOe_n = busOeQ_n;

endmodule // fdd_density_config

`default_nettype wire

// ==== verification/fdd_density_config_chk.sv ====
// Checker for the drive density configuration block
`timescale 1ns/1ps
`default_nettype none
module fdd_density_config_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic cfgRead,
  input wire logic [7:0] cfgIndex,
  input wire logic [7:0] cfgReadData,
  input wire logic cfgReadValid,
  input wire logic dmaModeWrite,
  input wire logic dmaModeBurst,
  input wire logic dmaNonBurst,
  input wire logic dmaGateEnable,
  input wire logic powerDown,
  input wire logic irqOe_n,
  input wire logic dackOe_n,
  input wire logic dreqAccepted,
  input wire fdd_pkg::fdd_bus_mode_t busMode,
  input wire logic hostRead3f7,
  input wire logic [7:0] fdcByte3f7,
  input wire logic [7:0] busDataOut,
  input wire logic [7:0] busDataOe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic shut;
  assign shut = !dmaGateEnable || powerDown;
  sequence rdOff;
    cfgRead && cfgIndex != 8'hF4 && cfgIndex != 8'hF5;
  endsequence
  sequence rdAt;
    hostRead3f7 && busMode == fdd_pkg::FDD_MODE_AT;
  endsequence
  sequence rdWide;
    hostRead3f7 && busMode != fdd_pkg::FDD_MODE_AT;
  endsequence
  AST_IRQ_FLOAT: assert property (shut |-> irqOe_n)
    else $error("irq driven while gated");
  AST_DACK_FLOAT: assert property (shut |-> dackOe_n)
    else $error("dack driven while gated");
  AST_DREQ_IGNORED: assert property (shut |-> !dreqAccepted)
    else $error("dreq taken while gated");
  AST_READ_VALID: assert property (cfgRead |=> cfgReadValid)
    else $error("read answer missing");
  AST_VALID_PULSE: assert property (!cfgRead |=> !cfgReadValid)
    else $error("read answer without read");
  AST_RESERVED_ZERO: assert property (cfgRead |=> (cfgReadData & 8'hA4) == 8'h00)
    else $error("reserved bits not zero");
  AST_RESET_DEFAULTS: assert property ($fell(reset) |-> dmaNonBurst && !cfgReadValid)
    else $error("reset defaults wrong");
  AST_UNMAPPED_ZERO: assert property (rdOff |=> cfgReadValid && cfgReadData == 8'h00)
    else $error("unmapped read not zero");
  AST_DMA_MODE: assert property (dmaModeWrite |=> dmaNonBurst == !$past(dmaModeBurst))
    else $error("dma mode not loaded");
  AST_AT_BIT7: assert property (rdAt |=> busDataOe_n == 8'h7F &&
    busDataOut[7] == $past(fdcByte3f7[7]))
    else $error("at mode drive wrong");
  AST_WIDE_BYTE: assert property (rdWide |=> busDataOe_n == 8'h00 &&
    busDataOut == $past(fdcByte3f7))
    else $error("byte drive wrong");
  AST_RELEASE: assert property (!hostRead3f7 |=> busDataOe_n == 8'hFF)
    else $error("bus not released");
endmodule // fdd_density_config_chk
bind fdd_density_config fdd_density_config_chk u_chk (.clock, .reset, .cfgRead, .cfgIndex,
  .cfgReadData, .cfgReadValid, .dmaModeWrite, .dmaModeBurst, .dmaNonBurst, .dmaGateEnable,
  .powerDown, .irqOe_n, .dackOe_n, .dreqAccepted, .busMode, .hostRead3f7, .fdcByte3f7,
  .busDataOut, .busDataOe_n);
`default_nettype wire

// ==== verification/fdd_drive_model.sv ====
// Drive model that senses the two density select pins
`timescale 1ns/1ps
`default_nettype none
module fdd_drive_model (
  input wire logic pinA,
  input wire logic pinB,
  output logic [1:0] sensed
);
  // Drive reads the pin pair as one density code
  assign sensed = {pinA, pinB};
endmodule // fdd_drive_model
`default_nettype wire

// ==== verification/fdd_density_config_tb.sv ====
// Testbench for the drive density configuration block
`timescale 1ns/1ps
`default_nettype none
module fdd_density_config_tb;
  logic clock = 1'b0, reset = 1'b1, cfgWrite = 1'b0, cfgRead = 1'b0, driveSel = 1'b0;
  logic dmaModeWrite = 1'b0, dmaModeBurst = 1'b0, dmaGateEnable = 1'b0, powerDown = 1'b0;
  logic controllerIrq = 1'b0, controllerDack = 1'b0, dreqPin = 1'b0, hostRead3f7 = 1'b0;
  logic [7:0] cfgIndex = 8'h00, cfgWriteData = 8'h00, fdcByte3f7 = 8'h00;
  logic [1:0] dataRateSel = 2'h0;
  fdd_pkg::fdd_bus_mode_t busMode = fdd_pkg::FDD_MODE_AT;
  logic [7:0] cfgReadData, busDataOut, busDataOe_n;
  logic cfgReadValid, precompEnable, drivePinA, drivePinB, dmaNonBurst, irqOut, irqOe_n;
  logic dackOut, dackOe_n, dreqAccepted;
  logic [1:0] sensed;
  fdd_pkg::fdd_bitrate_t bitRate;
  int fails = 0, checks = 0, cycles = 0;
  fdd_density_config u_fdd_density_config (.clock, .reset, .cfgWrite, .cfgRead, .cfgIndex,
    .cfgWriteData, .cfgReadData, .cfgReadValid, .driveSel, .dataRateSel, .precompEnable,
    .bitRate, .drivePinA, .drivePinB, .dmaModeWrite, .dmaModeBurst, .dmaNonBurst,
    .dmaGateEnable, .powerDown, .controllerIrq, .controllerDack, .dreqPin, .irqOut, .irqOe_n,
    .dackOut, .dackOe_n, .dreqAccepted, .busMode, .hostRead3f7, .fdcByte3f7, .busDataOut,
    .busDataOe_n);
  fdd_drive_model u_fdd_drive_model (.pinA(drivePinA), .pinB(drivePinB), .sensed(sensed));
  initial forever #25 clock = ~clock;
  // Expected {bitRate, pinA, pinB} for a drive register and a select code
  function automatic logic [4:0] expPins(input logic [7:0] c, input logic [1:0] s);
    logic den;
    logic [2:0] r;
    logic [1:0] p;
    den = (s == 2'h3) || (s == 2'h0);
    case (s)
      2'h3: r = 3'h2;
      2'h0: r = 3'h3;
      2'h2: r = 3'h0;
      default: r = (c[4:3] == 2'h1) ? 3'h3 : (c[4:3] == 2'h2) ? 3'h6 : 3'h1;
    endcase
    case (c[1:0])
      2'h0: p = {den, s[0]};
      2'h1: p = {s[1], s[0]};
      2'h2: p = {~den, s[0]};
      default: p = {s[0], s[1]};
    endcase
    return {r, p};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    cfgWrite = 1'b1;
    cfgIndex = idx;
    cfgWriteData = d;
    step(1);
    cfgWrite = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    cfgRead = 1'b1;
    cfgIndex = idx;
    step(1);
    cfgRead = 1'b0;
    chk(cfgReadValid, 1'b1); // Read strobe
    chk(cfgReadData, exp); // Read answer
    step(1);
  endtask
  task complete_run();
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] v, e;
    v = 8'($urandom(32'hA746));
    step(16);
    reset = 1'b0;
    step(1);
    rd(8'hF4, 8'h00); // Reset value
    rd(8'hF5, 8'h00); // Reset value
    chk(dmaNonBurst, 1'b1); // Non-burst default
    chk(precompEnable, 1'b1); // Precomp on
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      wr({7'h7A, i[0]}, v);
      rd({7'h7A, i[0]}, v & 8'h5B); // Reserved bits zero
    end
    wr(8'hF6, 8'hFF);
    rd(8'hF6, 8'h00); // Unmapped
    rd(8'hF3, 8'h00); // Unmapped
    for (int d = 0; d < 2; d++) for (int t = 0; t < 4; t++) for (int k = 0; k < 4; k++)
      for (int s = 0; s < 4; s++) begin
        v = {1'b0, 1'($urandom()), 1'b0, t[1:0], 1'b0, k[1:0]};
        wr({7'h7A, d[0]}, v);
        driveSel = d[0];
        dataRateSel = s[1:0];
        step(2);
        chk({3'h0, bitRate, sensed}, {3'h0, expPins(v, s[1:0])}); // Rate
        chk(precompEnable, !v[6]); // Precomp
      end
    for (int b = 1; b >= 0; b--) begin
      dmaModeBurst = b[0];
      dmaModeWrite = 1'b1;
      step(1);
      dmaModeWrite = 1'b0;
      chk(dmaNonBurst, !b[0]); // DMA mode
      step(1);
    end
    // Mid-run reset with burst mode and non-zero registers
    dmaModeBurst = 1'b1;
    dmaModeWrite = 1'b1;
    step(1);
    dmaModeWrite = 1'b0;
    chk(dmaNonBurst, 1'b0); // Burst loaded
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    chk(dmaNonBurst, 1'b1); // Non-burst after reset
    chk({3'h0, bitRate, sensed}, 8'h0E); // Reset values of the registered rate and pins
    step(1);
    rd(8'hF4, 8'h00); // Cleared
    rd(8'hF5, 8'h00); // Cleared
    for (int g = 0; g < 4; g++) begin
      dmaGateEnable = g[0];
      powerDown = g[1];
      controllerIrq = 1'($urandom());
      controllerDack = 1'b1;
      dreqPin = 1'b1;
      step(6);
      chk({irqOe_n, dackOe_n, dreqAccepted}, {g != 1, g != 1, g == 1}); // Gating
      chk({irqOut, dackOut}, {controllerIrq, controllerDack}); // Pass-through
      dreqPin = 1'b0;
      step(6);
      chk(dreqAccepted, 1'b0); // Idle request
    end
    for (int m = 0; m < 4; m++) if (m != 2) begin
      busMode = fdd_pkg::fdd_bus_mode_t'(m[1:0]);
      fdcByte3f7 = 8'($urandom());
      hostRead3f7 = 1'b1;
      step(1);
      e = (m == 0) ? 8'h7F : 8'h00;
      chk(busDataOe_n, e); // Drive width
      chk(busDataOut & ~e, fdcByte3f7 & ~e); // Driven bits
      hostRead3f7 = 1'b0;
      step(1);
      chk(busDataOe_n, 8'hFF); // Released
    end
    complete_run();
  end
endmodule // fdd_density_config_tb
`default_nettype wire
